//--- verilog/lfsa_pkg.sv
// Contract
// RL1: enable and no fault light ready and power, raise all status outputs, and light emission only under command pulses.
// RL2: without enable, ready, emission and laser permitted are off while the rest stay on.
// RL3: over-temperature flashes ready, darkens emission and lowers permitted and thermal good only.
// RL4: a supply fault blinks power, darkens ready and emission and lowers supply good and permitted only.
// RL5: a pulse-sense or board fault flashes ready and power, darkens emission and lowers permitted only.
// RL6: a coded fault blinks its count, pauses half a second and repeats.
// RL7: faults stay latched until the outside party fixes the cause and cycles power.
// RL8: over-temperature flashes ready, under-, over-voltage and supply-sense blink power 1, 2 and 3 times, a board fault flashes both.
// RL9: a voltage fault needs the condition to last more than 420 ms.
// RL10: enable loss is not latched; ready and permitted return at once with enable.
// RL11: blink on, off and pause times are configurable counts of the system clock.
package lfsa_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 10000000;
  localparam int unsigned CNT_W         = 24;
  localparam int unsigned BLINK_ON_MS   = 250;
  localparam int unsigned BLINK_OFF_MS  = 250;
  localparam int unsigned PAUSE_MS      = 500;
  localparam int unsigned VQUAL_MS      = 420;
  localparam int unsigned CMD_HOLD_US   = 1000;
  localparam int unsigned BLINK_ON_CYC  = BLINK_ON_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_OFF_CYC = BLINK_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned PAUSE_CYC     = PAUSE_MS * (CLK_HZ / 1000);
  localparam int unsigned VQUAL_CYC     = VQUAL_MS * (CLK_HZ / 1000);
  localparam int unsigned CMD_HOLD_CYC  = CMD_HOLD_US * (CLK_HZ / 1000000);

  // ****************************************************************
  // blink codes
  // ****************************************************************
  localparam logic [1:0] CODE_FLASH = 2'h0;
  localparam logic [1:0] CODE_UV    = 2'h1;
  localparam logic [1:0] CODE_OV    = 2'h2;
  localparam logic [1:0] CODE_DCS   = 2'h3;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int unsigned ADDR_W       = 4;
  localparam logic [3:0]  OFS_CTRL     = 4'h0;
  localparam logic [3:0]  OFS_STATUS   = 4'h4;
  localparam logic [3:0]  OFS_FAULT    = 4'h8;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam int unsigned CTRL_LTEST_B = 0;
  localparam int unsigned ST_EN_B      = 0;
  localparam int unsigned ST_CMD_B     = 1;
  localparam int unsigned ST_PERMIT_B  = 2;
  localparam int unsigned ST_TGOOD_B   = 3;
  localparam int unsigned ST_SGOOD_B   = 4;
  localparam int unsigned ST_PWR_B     = 5;
  localparam int unsigned ST_RDY_B     = 6;
  localparam int unsigned ST_EMIT_B    = 7;
  localparam int unsigned FLT_OT_B     = 0;
  localparam int unsigned FLT_UV_B     = 1;
  localparam int unsigned FLT_OV_B     = 2;
  localparam int unsigned FLT_DCS_B    = 3;
  localparam int unsigned FLT_PWM_B    = 4;
  localparam int unsigned NFLT         = 5;

  typedef enum logic [1:0] {
    LFSA_BL_IDLE  = 2'b00,
    LFSA_BL_ON    = 2'b01,
    LFSA_BL_OFF   = 2'b11,
    LFSA_BL_PAUSE = 2'b10
  } lfsa_blink_t;

endpackage

//--- verilog/lfsa_persist.sv
`timescale 1ns/100ps
// flags a level once it has stood for more than hold_cycles cycles
module lfsa_persist #(
  parameter logic [lfsa_pkg::CNT_W-1:0] HOLD_CYC = lfsa_pkg::CNT_W'(lfsa_pkg::VQUAL_CYC)
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic level_in,
  output logic      held
);

  logic [lfsa_pkg::CNT_W-1:0] cnt_reg;

  // any gap restarts the count, so short excursions never qualify
  always_ff @(posedge core_clk) begin
    if (srst || !level_in) begin
      cnt_reg <= '0;
    end else if (cnt_reg <= HOLD_CYC) begin
      cnt_reg <= cnt_reg + 1'b1; // RL9
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      held <= 1'b0;
    end else begin
      held <= level_in && (cnt_reg > HOLD_CYC); // RL9
    end
  end

endmodule

//--- verilog/lfsa_blinker.sv
`timescale 1ns/100ps
// lamp pattern: code n blinks n times then pauses; code zero flashes without pause
module lfsa_blinker #(
  parameter logic [lfsa_pkg::CNT_W-1:0] ON_CYC    = lfsa_pkg::CNT_W'(lfsa_pkg::BLINK_ON_CYC),
  parameter logic [lfsa_pkg::CNT_W-1:0] OFF_CYC   = lfsa_pkg::CNT_W'(lfsa_pkg::BLINK_OFF_CYC),
  parameter logic [lfsa_pkg::CNT_W-1:0] PAUSE_CYC = lfsa_pkg::CNT_W'(lfsa_pkg::PAUSE_CYC)
) (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic [1:0] code,
  output logic            lamp
);

  lfsa_pkg::lfsa_blink_t      state_reg;
  logic [lfsa_pkg::CNT_W-1:0] tmr_reg;
  logic [1:0]                 nblk_reg;
  logic                       tmr_done;

  assign tmr_done = (tmr_reg == '0);

  always_ff @(posedge core_clk) begin
    if (srst || !run) begin
      state_reg <= lfsa_pkg::LFSA_BL_IDLE;
      tmr_reg   <= '0;
      nblk_reg  <= '0;
    end else begin
      unique case (state_reg)
        lfsa_pkg::LFSA_BL_IDLE: begin
          state_reg <= lfsa_pkg::LFSA_BL_ON;
          tmr_reg   <= ON_CYC - 1'b1; // RL11
          nblk_reg  <= 2'h1;
        end
        lfsa_pkg::LFSA_BL_ON: begin
          if (tmr_done) begin
            state_reg <= lfsa_pkg::LFSA_BL_OFF;
            tmr_reg   <= OFF_CYC - 1'b1; // RL11
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
        lfsa_pkg::LFSA_BL_OFF: begin
          if (!tmr_done) begin
            tmr_reg <= tmr_reg - 1'b1;
          end else if (code == lfsa_pkg::CODE_FLASH || nblk_reg != code) begin
            state_reg <= lfsa_pkg::LFSA_BL_ON; // RL6
            tmr_reg   <= ON_CYC - 1'b1;
            nblk_reg  <= nblk_reg + 1'b1;
          end else begin
            state_reg <= lfsa_pkg::LFSA_BL_PAUSE;
            tmr_reg   <= PAUSE_CYC - 1'b1; // RL6
          end
        end
        lfsa_pkg::LFSA_BL_PAUSE: begin
          if (tmr_done) begin
            state_reg <= lfsa_pkg::LFSA_BL_ON; // RL6
            tmr_reg   <= ON_CYC - 1'b1;
            nblk_reg  <= 2'h1;
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
      endcase
    end
  end

  assign lamp = (state_reg == lfsa_pkg::LFSA_BL_ON);

endmodule

//--- verilog/lfsa_top.sv
`timescale 1ns/100ps
module lfsa_top #(
  parameter logic [lfsa_pkg::CNT_W-1:0] VQUAL_CYC    = lfsa_pkg::CNT_W'(lfsa_pkg::VQUAL_CYC),
  parameter logic [lfsa_pkg::CNT_W-1:0] ON_CYC       = lfsa_pkg::CNT_W'(lfsa_pkg::BLINK_ON_CYC),
  parameter logic [lfsa_pkg::CNT_W-1:0] OFF_CYC      = lfsa_pkg::CNT_W'(lfsa_pkg::BLINK_OFF_CYC),
  parameter logic [lfsa_pkg::CNT_W-1:0] PAUSE_CYC    = lfsa_pkg::CNT_W'(lfsa_pkg::PAUSE_CYC),
  parameter logic [lfsa_pkg::CNT_W-1:0] CMD_HOLD_CYC = lfsa_pkg::CNT_W'(lfsa_pkg::CMD_HOLD_CYC)
) (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  // pins from the machine side and the fault detectors
  input  wire logic                        laser_enable,
  input  wire logic                        cmd_pulse,
  input  wire logic                        overtemp_det,
  input  wire logic                        undervolt_det,
  input  wire logic                        overvolt_det,
  input  wire logic                        dcsense_det,
  input  wire logic                        pwmsense_det,
  // lamps
  output logic                             power_lamp,
  output logic                             ready_lamp,
  output logic                             emission_lamp,
  // status outputs
  output logic                             laser_permitted,
  output logic                             thermal_good,
  output logic                             supply_good,
  // avalon-mm slave
  input  wire logic [lfsa_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int unsigned NSYNC = 7;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;

  assign pin_raw = {pwmsense_det, dcsense_det, overvolt_det, undervolt_det,
                    overtemp_det, cmd_pulse, laser_enable};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (srst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic en_s;
  logic cmd_s;
  logic ot_s;
  logic uv_s;
  logic ov_s;
  logic dcs_s;
  logic pwm_s;

  assign en_s  = sync2_reg[0];
  assign cmd_s = sync2_reg[1];
  assign ot_s  = sync2_reg[2];
  assign uv_s  = sync2_reg[3];
  assign ov_s  = sync2_reg[4];
  assign dcs_s = sync2_reg[5];
  assign pwm_s = sync2_reg[6];

  // ****************************************************************
  // command pulse activity
  // ****************************************************************
  // retriggerable hold: any rising command edge keeps emission lit for the hold time,
  // so a command held high keeps it lit for one hold time only
  logic                       cmd_d_reg;
  logic [lfsa_pkg::CNT_W-1:0] cmd_tmr_reg;
  logic                       cmd_active;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_d_reg   <= 1'b0;
      cmd_tmr_reg <= '0;
    end else begin
      cmd_d_reg <= cmd_s;
      if (cmd_s && !cmd_d_reg) begin
        cmd_tmr_reg <= CMD_HOLD_CYC; // RL1
      end else if (cmd_tmr_reg != '0) begin
        cmd_tmr_reg <= cmd_tmr_reg - 1'b1;
      end
    end
  end

  assign cmd_active = (cmd_tmr_reg != '0);

  // ****************************************************************
  // supply persistence qualification
  // ****************************************************************
  logic uv_held;
  logic ov_held;

  lfsa_persist #(
    .HOLD_CYC (VQUAL_CYC)
  ) u_uv_persist (
    .core_clk (core_clk),
    .srst     (srst),
    .level_in (uv_s),
    .held     (uv_held)
  );

  lfsa_persist #(
    .HOLD_CYC (VQUAL_CYC)
  ) u_ov_persist (
    .core_clk (core_clk),
    .srst     (srst),
    .level_in (ov_s),
    .held     (ov_held)
  );

  // ****************************************************************
  // fault latches
  // ****************************************************************
  // only the power-on reset clears these; the detector going quiet is not enough
  logic [lfsa_pkg::NFLT-1:0] flt_reg;
  logic [lfsa_pkg::NFLT-1:0] flt_set;

  assign flt_set = {pwm_s, dcs_s, ov_held, uv_held, ot_s};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      flt_reg <= '0;
    end else begin
      flt_reg <= flt_reg | flt_set; // RL7
    end
  end

  logic f_ot;
  logic f_uv;
  logic f_ov;
  logic f_dcs;
  logic f_pwm;
  logic f_supply;

  assign f_ot     = flt_reg[lfsa_pkg::FLT_OT_B];
  assign f_uv     = flt_reg[lfsa_pkg::FLT_UV_B];
  assign f_ov     = flt_reg[lfsa_pkg::FLT_OV_B];
  assign f_dcs    = flt_reg[lfsa_pkg::FLT_DCS_B];
  assign f_pwm    = flt_reg[lfsa_pkg::FLT_PWM_B];
  assign f_supply = f_uv | f_ov | f_dcs;

  // ****************************************************************
  // blink pattern generators
  // ****************************************************************
  // with several supply faults the highest code wins, one pattern at a time
  logic [1:0] pwr_code;
  logic       pwr_pat;
  logic       flash_pat;

  always_comb begin
    if (f_dcs) begin
      pwr_code = lfsa_pkg::CODE_DCS; // RL8
    end else if (f_ov) begin
      pwr_code = lfsa_pkg::CODE_OV; // RL8
    end else begin
      pwr_code = lfsa_pkg::CODE_UV; // RL8
    end
  end

  lfsa_blinker #(
    .ON_CYC    (ON_CYC),
    .OFF_CYC   (OFF_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_pwr_blink (
    .core_clk (core_clk),
    .srst     (srst),
    .run      (f_supply),
    .code     (pwr_code),
    .lamp     (pwr_pat)
  );

  // one shared flasher keeps ready and power in phase for the board fault
  lfsa_blinker #(
    .ON_CYC    (ON_CYC),
    .OFF_CYC   (OFF_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) u_flash_blink (
    .core_clk (core_clk),
    .srst     (srst),
    .run      (f_ot | f_pwm),
    .code     (lfsa_pkg::CODE_FLASH),
    .lamp     (flash_pat)
  );

  // ****************************************************************
  // lamp and status outputs
  // ****************************************************************
  logic ctrl_ltest;
  logic any_fault;

  assign any_fault = |flt_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_lamp <= 1'b0;
    end else if (ctrl_ltest) begin
      power_lamp <= 1'b1;
    end else if (f_supply) begin
      power_lamp <= pwr_pat; // RL4
    end else if (f_pwm) begin
      power_lamp <= flash_pat; // RL5
    end else begin
      power_lamp <= 1'b1; // RL1 RL2 RL3
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ready_lamp <= 1'b0;
    end else if (ctrl_ltest) begin
      ready_lamp <= 1'b1;
    end else if (f_supply) begin
      ready_lamp <= 1'b0; // RL4
    end else if (f_ot || f_pwm) begin
      ready_lamp <= flash_pat; // RL3 RL5
    end else begin
      ready_lamp <= en_s; // RL1 RL2 RL10
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      emission_lamp <= 1'b0;
    end else if (ctrl_ltest) begin
      emission_lamp <= 1'b1;
    end else begin
      emission_lamp <= en_s && !any_fault && cmd_active; // RL1 RL2 RL3 RL4 RL5
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      laser_permitted <= 1'b0;
      thermal_good    <= 1'b0;
      supply_good     <= 1'b0;
    end else begin
      laser_permitted <= en_s && !any_fault; // RL1 RL2 RL3 RL4 RL5 RL10
      thermal_good    <= !f_ot; // RL3
      supply_good     <= !f_supply; // RL4
    end
  end

  // ****************************************************************
  // register slave
  // ****************************************************************
  // one wait cycle per access: waitrequest drops for exactly one cycle
  logic [31:0] ctrl_reg;
  logic [31:0] rd_mux;
  logic        acc_req;

  assign acc_req    = avs_read | avs_write;
  assign ctrl_ltest = ctrl_reg[lfsa_pkg::CTRL_LTEST_B];

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      lfsa_pkg::OFS_CTRL: begin
        rd_mux = ctrl_reg;
      end
      lfsa_pkg::OFS_STATUS: begin
        rd_mux[lfsa_pkg::ST_EN_B]     = en_s;
        rd_mux[lfsa_pkg::ST_CMD_B]    = cmd_active;
        rd_mux[lfsa_pkg::ST_PERMIT_B] = laser_permitted;
        rd_mux[lfsa_pkg::ST_TGOOD_B]  = thermal_good;
        rd_mux[lfsa_pkg::ST_SGOOD_B]  = supply_good;
        rd_mux[lfsa_pkg::ST_PWR_B]    = power_lamp;
        rd_mux[lfsa_pkg::ST_RDY_B]    = ready_lamp;
        rd_mux[lfsa_pkg::ST_EMIT_B]   = emission_lamp;
      end
      lfsa_pkg::OFS_FAULT: begin
        rd_mux[lfsa_pkg::NFLT-1:0] = flt_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (acc_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // the write lands on the edge where the master sees waitrequest low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= lfsa_pkg::CTRL_RST;
    end else if (avs_write && !avs_waitrequest && avs_address == lfsa_pkg::OFS_CTRL
                 && avs_byteenable[0]) begin
      ctrl_reg[0] <= avs_writedata[lfsa_pkg::CTRL_LTEST_B];
    end
  end

endmodule

//--- verif/lfsa_top_monitor.sv
`timescale 1ns/100ps
// ****************************************************************
// checker on the annunciator ports
// ****************************************************************
module lfsa_top_monitor #(
  parameter logic [lfsa_pkg::CNT_W-1:0] VQUAL_CYC    = 24'h14,
  parameter logic [lfsa_pkg::CNT_W-1:0] ON_CYC       = 24'h4,
  parameter logic [lfsa_pkg::CNT_W-1:0] OFF_CYC      = 24'h4,
  parameter logic [lfsa_pkg::CNT_W-1:0] PAUSE_CYC    = 24'hA,
  parameter logic [lfsa_pkg::CNT_W-1:0] CMD_HOLD_CYC = 24'h8
) (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        laser_enable,
  input wire logic        cmd_pulse,
  input wire logic        undervolt_det,
  input wire logic        overvolt_det,
  input wire logic        dcsense_det,
  input wire logic        power_lamp,
  input wire logic        ready_lamp,
  input wire logic        emission_lamp,
  input wire logic        laser_permitted,
  input wire logic        thermal_good,
  input wire logic        supply_good,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest
);
  logic [23:0] on_run;
  logic [23:0] off_run;
  logic [23:0] since_cmd;
  logic [23:0] v_run;
  logic [23:0] vmax;
  logic        pf_seen;
  logic        dcs_seen;
  logic        ltest;
  logic        lt2;
  logic        lt_any;

  // run lengths of the power lamp and time since the last command edge
  always_ff @(posedge core_clk) begin
    on_run    <= power_lamp ? on_run + 24'h1 : 24'h0;
    off_run   <= power_lamp ? 24'h0 : off_run + 24'h1;
    since_cmd <= srst ? 24'h800000 : ($rose(cmd_pulse) ? 24'h0 : since_cmd + 24'h1);
    v_run     <= (undervolt_det || overvolt_det) ? v_run + 24'h1 : 24'h0;
    vmax      <= srst ? 24'h0 : ((v_run > vmax) ? v_run : vmax);
  end

  // armed at the first rise of the code: the dip on entry is no real gap
  always_ff @(posedge core_clk) begin
    pf_seen  <= !srst && (pf_seen || (!supply_good && $rose(power_lamp)));
    dcs_seen <= !srst && (dcs_seen || dcsense_det);
  end

  // lamp test shadow, lamps lag the control bit by one register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ltest <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_address == lfsa_pkg::OFS_CTRL
                 && avs_byteenable[0]) begin
      ltest <= avs_writedata[0];
    end
    lt2 <= srst ? 1'b0 : ltest;
  end
  assign lt_any = ltest | lt2;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_EMIT_PERMIT: assert property (
    emission_lamp && !lt_any |-> laser_permitted && ready_lamp && thermal_good && supply_good)
    else $error("emission unpermitted");
  AST_EMIT_CMD: assert property (
    emission_lamp && !lt_any |-> since_cmd <= CMD_HOLD_CYC + 24'h6)
    else $error("emission without command");
  AST_NO_ENABLE: assert property (
    !laser_enable [*5] |-> !laser_permitted && (lt_any || !emission_lamp))
    else $error("lasing without enable");
  AST_THERMAL: assert property (
    !thermal_good |-> !laser_permitted && (lt_any || !emission_lamp))
    else $error("thermal fault lasing");
  AST_SUPPLY: assert property (
    !supply_good |-> !laser_permitted && (lt_any || (!ready_lamp && !emission_lamp)))
    else $error("supply fault lamps");
  AST_BLINK_ON: assert property (
    $fell(power_lamp) && pf_seen && !lt_any |-> on_run == ON_CYC)
    else $error("blink on-time");
  AST_BLINK_GAP: assert property (
    $rose(power_lamp) && pf_seen && !lt_any |->
      (off_run == OFF_CYC) || (off_run == OFF_CYC + PAUSE_CYC))
    else $error("blink gap");
  AST_TG_LATCH: assert property (
    $fell(thermal_good) |=> !thermal_good [*8])
    else $error("thermal fault not latched");
  AST_SG_LATCH: assert property (
    $fell(supply_good) |-> ##1 $stable(supply_good) [*8])
    else $error("supply fault not latched");
  AST_VQUAL: assert property (
    $fell(supply_good) && !dcs_seen |-> vmax > VQUAL_CYC)
    else $error("voltage fault early");
endmodule

bind lfsa_top lfsa_top_monitor #(
  .VQUAL_CYC(VQUAL_CYC), .ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC),
  .PAUSE_CYC(PAUSE_CYC), .CMD_HOLD_CYC(CMD_HOLD_CYC)
) i_lfsa_top_monitor (.*);

//--- verif/lfsa_ctrl_model.sv
`timescale 1ns/100ps
// ****************************************************************
// machine controller: drives enable and command, reads status
// ****************************************************************
module lfsa_ctrl_model (
  input  wire logic core_clk,
  input  wire logic en_req,
  input  wire logic pulse_req,
  input  wire logic laser_permitted,
  input  wire logic thermal_good,
  input  wire logic supply_good,
  output logic      laser_enable,
  output logic      cmd_pulse,
  output logic      lasing_ok
);
  logic [1:0] ph = 2'h0;
  // one-cycle pulses every four cycles stay well inside the command hold time
  always @(posedge core_clk) begin
    ph           <= ph + 2'h1;
    laser_enable <= en_req;
    cmd_pulse    <= pulse_req && ph == 2'h0;
  end
  assign lasing_ok = laser_permitted & thermal_good & supply_good;
endmodule

//--- verif/test_lfsa_top.sv
`timescale 1ns/100ps
module test_lfsa_top;
  // ****************************************************************
  // clock, stimulus and design
  // ****************************************************************
  localparam logic [23:0] VQ = 24'h14;
  localparam logic [23:0] OFF = 24'h4;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        en_req = 1'b0;
  logic        pulse_req = 1'b0;
  logic [4:0]  det = 5'h00;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        laser_enable, cmd_pulse, lasing_ok, power_lamp, ready_lamp, emission_lamp;
  logic        laser_permitted, thermal_good, supply_good;
  int          miscompares = 0;
  int          n_tests = 0;
  int          exp_pwr[5] = '{-1, 1, 2, 3, 0};
  int          exp_rdy[5] = '{0, -2, -2, -2, 0};

  always #50 core_clk = ~core_clk;

  lfsa_top #(
    .VQUAL_CYC(VQ), .ON_CYC(24'h4), .OFF_CYC(OFF), .PAUSE_CYC(24'hA), .CMD_HOLD_CYC(24'h8)
  ) i_lfsa_top (
    .overtemp_det(det[0]), .undervolt_det(det[1]), .overvolt_det(det[2]),
    .dcsense_det(det[3]), .pwmsense_det(det[4]), .*
  );

  lfsa_ctrl_model i_lfsa_ctrl_model (.*);

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address    <= a;
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      chk(32'h0, 32'h1, "bus timeout");
      summarize();
    end
  endtask

  task automatic power_cycle(input int n);
    @(posedge core_clk);
    srst <= 1'b1;
    cyc(n);
    srst <= 1'b0;
    cyc(6);
  endtask

  // blinks per code; 0 continuous flash, -1 steady lit, -2 dark
  task automatic measure(input logic which, output int n);
    int   gap, rises, pauses;
    logic lamp;
    gap = 0;
    rises = 0;
    pauses = 0;
    n = 0;
    repeat (200) begin
      @(posedge core_clk);
      #1 lamp = which ? ready_lamp : power_lamp;
      if (lamp !== 1'b1) begin
        gap++;
      end else if (gap > 0) begin
        rises++;
        if (gap > OFF + 2) pauses++;
        if (pauses == 1) n++;
        gap = 0;
      end
    end
    if (rises == 0) n = (lamp === 1'b1) ? -1 : -2;
    else if (pauses < 2) n = 0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_normal();
    logic [31:0] rd;
    @(posedge core_clk);
    en_req    <= 1'b1;
    pulse_req <= 1'b1;
    cyc(20);
    chk({power_lamp, ready_lamp, emission_lamp, laser_permitted, thermal_good,
         supply_good, lasing_ok}, 7'h7F, "normal outputs");
    bus(1'b0, lfsa_pkg::OFS_STATUS, 32'h0, 4'hF, rd);
    chk(rd & 32'hFD, 32'hFD, "status word");
    bus(1'b0, lfsa_pkg::OFS_FAULT, 32'h0, 4'hF, rd);
    chk(rd, 32'h0, "no faults");
    bus(1'b0, 4'hC, 32'h0, 4'hF, rd);
    chk(rd, 32'h0, "unmapped read");
    pulse_req <= 1'b0;
    cyc(20);
    chk({ready_lamp, emission_lamp}, 2'b10, "no command pulses");
    $display("done normal");
  endtask

  task automatic t_enable();
    logic [31:0] rd;
    @(posedge core_clk);
    en_req    <= 1'b0;
    pulse_req <= 1'b1;
    cyc(8);
    chk({power_lamp, ready_lamp, emission_lamp, laser_permitted, thermal_good,
         supply_good}, 6'b100011, "enable absent");
    bus(1'b1, lfsa_pkg::OFS_CTRL, 32'h1, 4'hE, rd);
    bus(1'b0, lfsa_pkg::OFS_CTRL, 32'h0, 4'hF, rd);
    chk(rd, lfsa_pkg::CTRL_RST, "masked control write");
    bus(1'b1, lfsa_pkg::OFS_CTRL, 32'h1, 4'hF, rd);
    cyc(3);
    chk({power_lamp, ready_lamp, emission_lamp, laser_permitted}, 4'hE, "lamp test");
    bus(1'b1, lfsa_pkg::OFS_CTRL, 32'h0, 4'hF, rd);
    en_req <= 1'b1;
    cyc(6);
    chk({ready_lamp, laser_permitted}, 2'b11, "enable restored");
    $display("done enable");
  endtask

  // detector released before judging, so checks see the latch
  task automatic t_fault(input int i);
    int          pc, rc;
    logic [31:0] rd;
    power_cycle(3);
    if (i == 1 || i == 2) begin
      det[i] <= 1'b1;
      cyc(VQ);
      det[i] <= 1'b0;
      cyc(8);
      chk(supply_good, 1'b1, "short excursion");
    end
    det[i] <= 1'b1;
    cyc(VQ + 6);
    det[i] <= 1'b0;
    cyc(6);
    chk({laser_permitted, emission_lamp, thermal_good, supply_good},
        {2'b00, i != 0, i == 0 || i == 4}, "fault outputs");
    measure(1'b0, pc);
    chk(pc, exp_pwr[i], "power lamp code");
    measure(1'b1, rc);
    chk(rc, exp_rdy[i], "ready lamp code");
    bus(1'b0, lfsa_pkg::OFS_FAULT, 32'h0, 4'hF, rd);
    chk(rd, 32'h1 << i, "fault latched");
    power_cycle(3);
    cyc(4);
    chk({laser_permitted, thermal_good, supply_good}, 3'b111, "cleared by power cycle");
    $display("done fault %0d", i);
  endtask

  initial begin
    power_cycle(16);
    t_normal();
    t_enable();
    for (int i = 0; i < 5; i++) begin
      t_fault(i);
    end
    summarize();
  end
endmodule
